// *** hdl/pef_pkg.sv ***
package pef_pkg;
   // register indices (byte address = 4 x index)
   localparam logic [7:0] PEF_STATUS_IDX  = 8'h0a;
   localparam logic [7:0] PEF_ACK_IDX     = 8'h0b;
   localparam logic [7:0] PEF_MASK_IDX    = 8'h0c;
   localparam logic [7:0] PEF_SEQCFG_IDX  = 8'h0d;
   localparam logic [9:0] PEF_STATUS_ADDR = {PEF_STATUS_IDX, 2'b00};
   localparam logic [9:0] PEF_ACK_ADDR    = {PEF_ACK_IDX, 2'b00};
   localparam logic [9:0] PEF_MASK_ADDR   = {PEF_MASK_IDX, 2'b00};
   localparam logic [9:0] PEF_SEQCFG_ADDR = {PEF_SEQCFG_IDX, 2'b00};
   // flag positions, shared by status, acknowledge and mask
   localparam int PEF_BIT_WARN = 0;
   localparam int PEF_BIT_TSD  = 1;
   localparam int PEF_BIT_PUS  = 2;
   localparam int PEF_BIT_UVLO = 3;
   localparam int PEF_NFLAG    = 4;
   localparam logic [7:0] PEF_ACK_RESET    = 8'h00;
   localparam logic [7:0] PEF_MASK_RESET   = 8'h00;
   localparam logic [7:0] PEF_SEQCFG_RESET = 8'h10;
   // power-up delay: periods of a slot time
   localparam int PEF_SLOT_US     = 128;
   localparam int PEF_CLK_MHZ     = 40;
   localparam int PEF_SLOT_CYC    = PEF_SLOT_US * PEF_CLK_MHZ;
   localparam int PEF_PUS_PERIODS = 16;
   typedef logic [PEF_NFLAG-1:0] pef_vec_t;
   // synced levels out of reset: power-up sense idles high
   localparam pef_vec_t PEF_LEVEL_RESET = 4'h4;
endpackage

// *** hdl/pef_edge_if.sv ***
`timescale 1ns/10ps
interface pef_edge_if;
   logic [3:0] level;
   logic [3:0] rise;
   logic [3:0] fall;
   modport det (output rise, output fall, input level);
   modport usr (input rise, input fall, output level);
endinterface

// *** hdl/pef_edge_det.sv ***
`timescale 1ns/10ps
module pef_edge_det
#(
   parameter pef_pkg::pef_vec_t IDLE_LEVEL = '0
)
(
   // clock and reset
   input  wire logic mclk_in,
   input  wire logic reset_in,
   // levels in, edges out
   pef_edge_if.det   edges
);
   import pef_pkg::*;
   typedef struct packed {
      pef_vec_t prev;
   } pef_det_st_t;
   pef_det_st_t st;
   pef_det_st_t next_st;
   always_comb
   begin
      next_st.prev = edges.level;
   end
   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      // idle level, not zero: a high pin would fake an edge after reset
      if (reset_in)
         st.prev <= IDLE_LEVEL;
      else
         st <= next_st;
   end
   // edges seen against the previous sample
   assign edges.rise = edges.level & ~st.prev;
   assign edges.fall = ~edges.level & st.prev;
endmodule // pef_edge_det

// *** hdl/pef_event_flags.sv ***
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module pef_event_flags
#(
   parameter int SLOT_CYC = pef_pkg::PEF_SLOT_CYC
)
(
   // clock and reset
   input  wire logic        mclk_in,
   input  wire logic        reset_in,
   // sense pins
   input  wire logic        undervoltage_sense_in,
   input  wire logic        thermal_shutdown_sense_in,
   input  wire logic        thermal_warning_sense_in,
   input  wire logic        hardware_enable_input_in,
   // register port
   input  wire logic [9:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [31:0] rdata_out,
   // interrupt and status
   output logic             irq_out,
   output logic             powerup_done_sense_out
);
   import pef_pkg::*;

   typedef struct packed {
      logic [1:0] s_uv;
      logic [1:0] s_tsd;
      logic [1:0] s_warn;
      logic [1:0] s_en;
      logic       en_q;
      logic       pus;
      logic [7:0] per_cnt;
      logic [15:0] cyc_cnt;
      pef_vec_t   ack;
      pef_vec_t   mask;
      logic [7:0] seqcfg;
      logic [31:0] rdata;
      logic       irq;
   } pef_st_t;

   pef_st_t st;
   pef_st_t next_st;
   pef_edge_if edges ();

   localparam logic [15:0] SLOT_LAST = 16'(SLOT_CYC - 1);

   // strobe aimed at one register; shared by the ack read, mask write and seqcfg write decodes
   function automatic logic pef_hit
   (
      input logic       strobe,
      input logic [9:0] addr,
      input logic [9:0] target
   );
      pef_hit = strobe && (addr == target);
   endfunction

   // which edges latch a flag: power-up only on its rising edge
   function automatic pef_vec_t pef_set_of
   (
      input pef_vec_t rise,
      input pef_vec_t fall
   );
      pef_vec_t v;
      v               = '0;
      v[PEF_BIT_UVLO] = rise[PEF_BIT_UVLO] | fall[PEF_BIT_UVLO];
      v[PEF_BIT_PUS]  = rise[PEF_BIT_PUS];
      v[PEF_BIT_TSD]  = rise[PEF_BIT_TSD] | fall[PEF_BIT_TSD];
      v[PEF_BIT_WARN] = rise[PEF_BIT_WARN] | fall[PEF_BIT_WARN];
      pef_set_of = v;
   endfunction

   // read mux; unmapped addresses read as zero
   function automatic logic [31:0] pef_read_mux
   (
      input logic [9:0] addr,
      input pef_vec_t   level,
      input pef_vec_t   ack,
      input pef_vec_t   mask,
      input logic [7:0] seqcfg
   );
      logic [31:0] r;
      r = '0;
      unique case (addr)
         PEF_STATUS_ADDR: r[PEF_NFLAG-1:0] = level;
         PEF_ACK_ADDR:    r[PEF_NFLAG-1:0] = ack;
         PEF_MASK_ADDR:   r[PEF_NFLAG-1:0] = mask;
         PEF_SEQCFG_ADDR: r[7:0]           = seqcfg;
         default:         r                = '0;
      endcase
      pef_read_mux = r;
   endfunction

   pef_edge_det
   #(
      .IDLE_LEVEL (PEF_LEVEL_RESET)
   )
   u_det
   (
      .mclk_in  (mclk_in),
      .reset_in (reset_in),
      .edges    (edges)
   );

   // second sync stage feeds edge detection; first stage read by nobody else
   assign edges.level = {st.s_uv[1], st.pus, st.s_tsd[1], st.s_warn[1]};

   always_comb
   begin
      pef_vec_t setv;
      logic     rd_ack;
      logic     wr_mask;
      logic     wr_seqcfg;
      logic     period_end;
      logic     last_period;
      next_st     = st;
      setv        = pef_set_of(edges.rise, edges.fall);
      rd_ack      = pef_hit(rd_in, addr_in, PEF_ACK_ADDR);
      wr_mask     = pef_hit(wr_in, addr_in, PEF_MASK_ADDR);
      wr_seqcfg   = pef_hit(wr_in, addr_in, PEF_SEQCFG_ADDR);
      period_end  = (st.cyc_cnt == SLOT_LAST);
      last_period = (st.per_cnt == st.seqcfg - 8'h01);
      // pins pass two flops before anything reads them
      next_st.s_uv   = {st.s_uv[0], undervoltage_sense_in};
      next_st.s_tsd  = {st.s_tsd[0], thermal_shutdown_sense_in};
      next_st.s_warn = {st.s_warn[0], thermal_warning_sense_in};
      next_st.s_en   = {st.s_en[0], hardware_enable_input_in};
      next_st.en_q   = st.s_en[1];
      // power-up sequencer; enable low forces the done level
      if (!st.s_en[1])
      begin
         next_st.pus     = 1'b1;
         next_st.per_cnt = '0;
         next_st.cyc_cnt = '0;
      end
      else if (!st.en_q)
      begin
         // enable has just risen: start counting periods
         next_st.pus     = 1'b0;
         next_st.per_cnt = '0;
         next_st.cyc_cnt = '0;
      end
      else if (!st.pus)
      begin
         if (period_end)
         begin
            next_st.cyc_cnt = '0;
            if (last_period)
            begin
               next_st.pus = 1'b1;
            end
            else
            begin
               next_st.per_cnt = st.per_cnt + 8'h01;
            end
         end
         else
         begin
            next_st.cyc_cnt = st.cyc_cnt + 16'h0001;
         end
      end
      // read clears; an edge in the same cycle still sets
      if (rd_ack)
      begin
         next_st.ack = setv;
      end
      else
      begin
         next_st.ack = st.ack | setv;
      end
      if (wr_mask)
      begin
         next_st.mask = wdata_in[PEF_NFLAG-1:0];
      end
      // zero periods would wrap to 256; clamp to one
      if (wr_seqcfg)
      begin
         next_st.seqcfg = (wdata_in[7:0] == 8'h00) ? 8'h01 : wdata_in[7:0];
      end
      // read data stand one cycle only, zero otherwise
      next_st.rdata = '0;
      if (rd_in)
      begin
         next_st.rdata = pef_read_mux(addr_in, edges.level, st.ack,
                                      st.mask, st.seqcfg);
      end
      // irq follows the new flags and mask in the same edge
      next_st.irq = |(next_st.ack & next_st.mask);
   end

   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         st        <= '0;
         st.pus    <= 1'b1;
         st.ack    <= PEF_ACK_RESET[PEF_NFLAG-1:0];
         st.mask   <= PEF_MASK_RESET[PEF_NFLAG-1:0];
         st.seqcfg <= PEF_SEQCFG_RESET;
      end
      else
         st <= next_st;
   end

   assign rdata_out              = st.rdata;
   assign irq_out                = st.irq;
   assign powerup_done_sense_out = st.pus;
endmodule // pef_event_flags

// *** dv/pef_event_flags_assertions.sv ***
`timescale 1ns/10ps
module pef_event_flags_assertions
   import pef_pkg::*;
#(
   parameter int SLOT_CYC = PEF_SLOT_CYC
)
(
   input wire logic        mclk_in, reset_in, wr_in, rd_in, irq_out,
   input wire logic        undervoltage_sense_in, thermal_shutdown_sense_in,
   input wire logic        thermal_warning_sense_in, hardware_enable_input_in,
   input wire logic        powerup_done_sense_out,
   input wire logic [9:0]  addr_in,
   input wire logic [31:0] wdata_in, rdata_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (reset_in);
   // quiet counter: cycles since any level seen at the pins last moved
   logic [4:0] s1;
   logic [3:0] qc;
   wire logic [4:0] s = {undervoltage_sense_in, thermal_shutdown_sense_in,
      thermal_warning_sense_in, hardware_enable_input_in,
      powerup_done_sense_out};
   wire logic ra = rd_in && addr_in == PEF_ACK_ADDR;
   always_ff @(posedge mclk_in or posedge reset_in)
      if (reset_in)
      begin
         s1 <= 5'h0;
         qc <= 4'h0;
      end
      else
      begin
         s1 <= s;
         qc <= (s != s1) ? 4'h0 : qc + {3'h0, qc != 4'hf};
      end
   rd_zero_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
      else $error("read data outside read slot");
   ack_clear_a: assert property (ra && qc > 4'h8 ##2 ra |=> rdata_out == 32'h0)
      else $error("flags survived a read");
   status_level_a: assert property (rd_in && addr_in == PEF_STATUS_ADDR && qc > 4'h4
      |=> rdata_out == {28'h0, s[4], s[0], s[3:2]})
      else $error("status differs from pins");
   enable_low_a: assert property (!hardware_enable_input_in [*4]
      |-> powerup_done_sense_out)
      else $error("power-up sense low while disabled");
   seq_low_a: assert property ($fell(powerup_done_sense_out)
      |-> !powerup_done_sense_out [*8])
      else $error("power-up sense rose too soon");
   mask_off_a: assert property (wr_in && addr_in == PEF_MASK_ADDR
      && wdata_in[3:0] == 4'h0 |-> ##2 !irq_out)
      else $error("interrupt with all flags masked");
   edge_irq_a: assert property ($rose(irq_out) |-> qc < 4'h8 || $past(wr_in))
      else $error("interrupt without an edge");
endmodule // pef_event_flags_assertions
bind pef_event_flags pef_event_flags_assertions #(.SLOT_CYC(SLOT_CYC)) u_chk (.*);

// *** dv/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
   import pef_pkg::*;
   logic        mclk_in = 0, reset_in = 1, wr = 0, rd = 0, irq, pus;
   logic [3:0]  sv = 0;
   logic [9:0]  addr = 0;
   logic [31:0] wd = 0, rdata;
   int          n_mismatch = 0, compares = 0;
   // short slot keeps the sixteen-period power-up near 64 cycles
   pef_event_flags #(.SLOT_CYC(4)) u_pef_event_flags (.mclk_in(mclk_in),
      .reset_in(reset_in), .undervoltage_sense_in(sv[3]),
      .thermal_shutdown_sense_in(sv[1]), .thermal_warning_sense_in(sv[0]),
      .hardware_enable_input_in(sv[2]), .addr_in(addr), .wdata_in(wd),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq),
      .powerup_done_sense_out(pus));
   initial forever #12.5 mclk_in = ~mclk_in;
   task automatic complete_run;
      if (n_mismatch == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("FAIL %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      {wr, rd, addr, wd} <= {w, !w, a, d};
      @(posedge mclk_in);
      {wr, rd} <= 2'b00;
      #1;
   endtask
   task automatic rdc(input logic [9:0] a, input logic [31:0] e);
      acc(0, a, 0);
      chk(rdata, e);
   endtask
   task automatic wt(input logic v);
      int i;
      for (i = 0; i < 200 && pus !== v; i++)
         @(negedge mclk_in);
      if (i == 200)
      begin
         n_mismatch++;
         complete_run;
      end
   endtask
   task automatic edges;
      int bl[3] = '{3, 1, 0};
      acc(1, PEF_MASK_ADDR, 32'hf);
      foreach (bl[i])
         for (int k = 1; k >= 0; k--)
         begin
            sv[bl[i]] <= k[0];
            repeat (6) @(posedge mclk_in);
            #1 chk(irq, 1);
            rdc(PEF_ACK_ADDR, 32'h1 << bl[i]);
            rdc(PEF_ACK_ADDR, 0);
            chk(irq, 0);
         end
      // masked flag still latches but stays quiet
      acc(1, PEF_MASK_ADDR, 0);
      sv[0] <= 1;
      repeat (6) @(posedge mclk_in);
      chk(irq, 0);
      rdc(PEF_ACK_ADDR, 1);
   endtask
   // flag set long before two reads that follow each other
   task automatic quiet_read;
      sv[1] <= 1'b1;
      repeat (12) @(posedge mclk_in);
      rdc(PEF_ACK_ADDR, 32'h2);
      rdc(PEF_ACK_ADDR, 0);
      sv[1] <= 1'b0;
      repeat (12) @(posedge mclk_in);
      rdc(PEF_ACK_ADDR, 32'h2);
      rdc(PEF_ACK_ADDR, 0);
   endtask
   task automatic powerup;
      realtime t0;
      sv[2] <= 1;
      t0 = $realtime;
      wt(0);
      rdc(PEF_ACK_ADDR, 0);
      wt(1);
      chk(($realtime - t0) >= 64 * 25 && ($realtime - t0) <= 68 * 25, 1);
      rdc(PEF_ACK_ADDR, 32'h4);
      sv <= 4'h0;
      repeat (8) @(posedge mclk_in);
      rdc(PEF_STATUS_ADDR, 32'h4);
   endtask
   initial
   begin
      repeat (3) @(posedge mclk_in);
      reset_in <= 0;
      rdc(PEF_ACK_ADDR, 0);
      chk(pus, 1);
      edges;
      rdc(PEF_ACK_ADDR, 0);
      quiet_read;
      powerup;
      rdc(10'h3fc, 0);
      complete_run;
   end
endmodule // tb_top
